/* tsr_pkg.sv */
// Constants for the temperature result and limit register block.
// Assumes an 8-bit register port, 11-bit signed remote codes and 8-bit unsigned local codes.
package tsr_pkg;
   localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h00;
   localparam logic [7:0] ADDR_REMOTE_HI = 8'h01;
   localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h05;
   localparam logic [7:0] ADDR_RHIGH_HI = 8'h07;
   localparam logic [7:0] ADDR_RLOW_HI = 8'h08;
   localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
   localparam logic [7:0] ADDR_ROFF_HI = 8'h11;
   localparam logic [7:0] ADDR_ROFF_LO = 8'h12;
   localparam logic [7:0] ADDR_RHIGH_LO = 8'h13;
   localparam logic [7:0] ADDR_RLOW_LO = 8'h14;
   localparam logic [7:0] ADDR_CRIT = 8'h19;
   localparam logic [7:0] ADDR_CRIT_HYST = 8'h21;
   localparam logic [7:0] ADDR_FILT_MODE = 8'hbf;
   localparam int TEMP_W = 11;
   localparam int FRAC_W = 3;
   localparam int FRAC_LSB = 5;
   localparam int FILT_LSB = 1;
   localparam int COMP_BIT = 0;
   localparam logic [7:0] RST_LOCAL_HIGH = 8'h46;
   localparam logic [10:0] RST_RHIGH = 11'h230;
   localparam logic [10:0] RST_RLOW = 11'h000;
   localparam logic [10:0] RST_ROFF = 11'h000;
   localparam logic [7:0] RST_CRIT = 8'h55;
   localparam logic [7:0] RST_CRIT_HYST = 8'h0a;
   localparam logic [2:0] RST_FILT_MODE = 3'h0;
   localparam logic [1:0] FILT_OFF = 2'h0;
   localparam logic [1:0] FILT_MAX = 2'h3;
endpackage

/* tsr_filter.sv */
// Smoothing filter for the raw remote converter code.
// Assumes one raw sample pulse at a time, synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module tsr_filter #(
   parameter int W = 11
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [1:0] level_i,
   input wire logic sample_i,
   input wire logic [W-1:0] raw_i,
   output logic valid_o,
   output logic [W-1:0] out_o
);
   typedef struct packed {
      logic valid;
      logic [W-1:0] y;
   } tsr_filt_t;
   tsr_filt_t st_reg, st_next;
   logic signed [W:0] diff;

   always_comb begin
      st_next = st_reg;
      st_next.valid = 1'b0;
      diff = $signed({raw_i[W-1], raw_i}) - $signed({st_reg.y[W-1], st_reg.y});
      if (sample_i) begin
         st_next.valid = 1'b1;
         case (level_i)
            tsr_pkg::FILT_OFF: st_next.y = raw_i;
            tsr_pkg::FILT_MAX: st_next.y = st_reg.y + W'(diff >>> 2);
            default: st_next.y = st_reg.y + W'(diff >>> 1);
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign valid_o = st_reg.valid;
   assign out_o = st_reg.y;
endmodule
`default_nettype wire

/* tsr_window_cmp.sv */
// Signed window comparison of a reading against high and low limits.
// Purely combinational; the caller registers what it keeps.
`timescale 1ns/1ps
`default_nettype none
module tsr_window_cmp #(
   parameter int W = 11
) (
   input wire logic [W-1:0] value_i,
   input wire logic [W-1:0] high_i,
   input wire logic [W-1:0] low_i,
   output logic above_o,
   output logic below_o
);
   assign above_o = $signed(value_i) > $signed(high_i);
   assign below_o = $signed(value_i) < $signed(low_i);
endmodule
`default_nettype wire

/* tsr_regs.sv */
// Temperature result, offset and limit registers with alert logic.
// Assumes converter samples and register accesses are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module tsr_regs (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic local_valid_i,
   input wire logic [7:0] local_code_i,
   input wire logic remote_valid_i,
   input wire logic [10:0] remote_code_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic alert_response_query_i,
   output logic [7:0] reg_rdata_o,
   output logic alert_o,
   output logic crit_o,
   output logic [3:0] alarm_o
);
   localparam int W = tsr_pkg::TEMP_W;
   localparam int F = tsr_pkg::FRAC_W;

   typedef struct packed {
      logic [7:0] local_temp;
      logic [W-1:0] remote;
      logic [F-1:0] frac_hold;
      logic [7:0] local_high;
      logic [W-1:0] rhigh;
      logic [W-1:0] rlow;
      logic [W-1:0] roff;
      logic [7:0] crit;
      logic [7:0] hyst;
      logic [2:0] mode;
      logic crit_act;
      logic alert_hold;
      logic [7:0] rdata;
   } tsr_state_t;

   tsr_state_t st_reg, st_next;
   logic filt_valid;
   logic [W-1:0] filt_out;
   logic rem_above, rem_below;
   logic local_above, crit_above, crit_below, any_cond;
   logic signed [W+1:0] sum;
   logic [W-1:0] sum_sat;
   logic signed [W+1:0] crit_on_lvl, crit_off_lvl;

   tsr_filter #(.W(W)) u_filter (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .level_i(st_reg.mode[tsr_pkg::FILT_LSB +: 2]),
      .sample_i(remote_valid_i),
      .raw_i(remote_code_i),
      .valid_o(filt_valid),
      .out_o(filt_out)
   );

   tsr_window_cmp #(.W(W)) u_cmp (
      .value_i(st_reg.remote),
      .high_i(st_reg.rhigh),
      .low_i(st_reg.rlow),
      .above_o(rem_above),
      .below_o(rem_below)
   );

   // Replace the bits 7:5 of a limit or offset low byte
   function automatic logic [W-1:0] set_frac(input logic [W-1:0] v,
                                             input logic [7:0] d);
      set_frac = {v[W-1:F], d[7 -: F]};
   endfunction

   // Replace the integer byte of an 11-bit value
   function automatic logic [W-1:0] set_int(input logic [W-1:0] v,
                                            input logic [7:0] d);
      set_int = {d, v[F-1:0]};
   endfunction

   // Offset is added, then clamped so a large offset cannot wrap sign
   always_comb begin
      sum = $signed({{2{filt_out[W-1]}}, filt_out})
          + $signed({{2{st_reg.roff[W-1]}}, st_reg.roff});
      if (sum > $signed({3'b000, {(W-1){1'b1}}})) begin
         sum_sat = {1'b0, {(W-1){1'b1}}};
      end else if (sum < $signed({3'b111, {(W-1){1'b0}}})) begin
         sum_sat = {1'b1, {(W-1){1'b0}}};
      end else begin
         sum_sat = sum[W-1:0];
      end
   end

   // Critical thresholds in eighths of a degree
   always_comb begin
      crit_on_lvl = $signed({{(W-9){st_reg.crit[7]}}, st_reg.crit, 3'b000});
      crit_off_lvl = crit_on_lvl
                   - $signed({{(W-9){1'b0}}, st_reg.hyst, 3'b000});
   end

   assign crit_above = $signed({{2{st_reg.remote[W-1]}}, st_reg.remote})
                     > crit_on_lvl;
   assign crit_below = $signed({{2{st_reg.remote[W-1]}}, st_reg.remote})
                     < crit_off_lvl;
   assign local_above = st_reg.local_temp > st_reg.local_high;
   assign any_cond = local_above | rem_above | rem_below | st_reg.crit_act;

   always_comb begin
      st_next = st_reg;
      if (local_valid_i) begin
         st_next.local_temp = local_code_i;
      end
      // Stored code keeps the eighth-degree scale the converter delivers
      if (filt_valid) begin
         st_next.remote = sum_sat;
      end
      if (crit_above) begin
         st_next.crit_act = 1'b1;
      end else if (crit_below) begin
         st_next.crit_act = 1'b0;
      end
      // Query clears the latch, but a live condition sets it again
      if (alert_response_query_i) begin
         st_next.alert_hold = 1'b0;
      end
      if (any_cond) begin
         st_next.alert_hold = 1'b1;
      end
      if (reg_wr_i) begin
         case (reg_addr_i)
            tsr_pkg::ADDR_LOCAL_HIGH: st_next.local_high = reg_wdata_i;
            tsr_pkg::ADDR_RHIGH_HI:
               st_next.rhigh = set_int(st_reg.rhigh, reg_wdata_i);
            tsr_pkg::ADDR_RHIGH_LO:
               st_next.rhigh = set_frac(st_reg.rhigh, reg_wdata_i);
            tsr_pkg::ADDR_RLOW_HI:
               st_next.rlow = set_int(st_reg.rlow, reg_wdata_i);
            tsr_pkg::ADDR_RLOW_LO:
               st_next.rlow = set_frac(st_reg.rlow, reg_wdata_i);
            tsr_pkg::ADDR_ROFF_HI:
               st_next.roff = set_int(st_reg.roff, reg_wdata_i);
            tsr_pkg::ADDR_ROFF_LO:
               st_next.roff = set_frac(st_reg.roff, reg_wdata_i);
            tsr_pkg::ADDR_CRIT: st_next.crit = reg_wdata_i;
            tsr_pkg::ADDR_CRIT_HYST: st_next.hyst = reg_wdata_i;
            // Upper bits are dropped, so a careless host cannot set them
            tsr_pkg::ADDR_FILT_MODE: st_next.mode = reg_wdata_i[2:0];
            default: begin
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            tsr_pkg::ADDR_LOCAL_TEMP: st_next.rdata = st_reg.local_temp;
            tsr_pkg::ADDR_REMOTE_HI: begin
               st_next.rdata = st_reg.remote[W-1:F];
               // Low byte is frozen so a pair comes from one conversion
               st_next.frac_hold = st_reg.remote[F-1:0];
            end
            tsr_pkg::ADDR_REMOTE_LO:
               st_next.rdata = {st_reg.frac_hold, 5'h00};
            tsr_pkg::ADDR_LOCAL_HIGH: st_next.rdata = st_reg.local_high;
            tsr_pkg::ADDR_RHIGH_HI: st_next.rdata = st_reg.rhigh[W-1:F];
            tsr_pkg::ADDR_RHIGH_LO:
               st_next.rdata = {st_reg.rhigh[F-1:0], 5'h00};
            tsr_pkg::ADDR_RLOW_HI: st_next.rdata = st_reg.rlow[W-1:F];
            tsr_pkg::ADDR_RLOW_LO:
               st_next.rdata = {st_reg.rlow[F-1:0], 5'h00};
            tsr_pkg::ADDR_ROFF_HI: st_next.rdata = st_reg.roff[W-1:F];
            tsr_pkg::ADDR_ROFF_LO:
               st_next.rdata = {st_reg.roff[F-1:0], 5'h00};
            tsr_pkg::ADDR_CRIT: st_next.rdata = st_reg.crit;
            tsr_pkg::ADDR_CRIT_HYST: st_next.rdata = st_reg.hyst;
            tsr_pkg::ADDR_FILT_MODE: st_next.rdata = {5'h00, st_reg.mode};
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
         st_reg.local_high <= tsr_pkg::RST_LOCAL_HIGH;
         st_reg.rhigh <= tsr_pkg::RST_RHIGH;
         st_reg.rlow <= tsr_pkg::RST_RLOW;
         st_reg.roff <= tsr_pkg::RST_ROFF;
         st_reg.crit <= tsr_pkg::RST_CRIT;
         st_reg.hyst <= tsr_pkg::RST_CRIT_HYST;
         st_reg.mode <= tsr_pkg::RST_FILT_MODE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata_o = st_reg.rdata;
   assign crit_o = st_reg.crit_act;
   assign alarm_o = {local_above, rem_above, rem_below, st_reg.crit_act};
   assign alert_o = st_reg.mode[tsr_pkg::COMP_BIT] ? any_cond
                  : st_reg.alert_hold;

   sequence s_hi_read;
      reg_rd_i && reg_addr_i == tsr_pkg::ADDR_REMOTE_HI;
   endsequence

   sequence s_lo_read;
      reg_rd_i && reg_addr_i == tsr_pkg::ADDR_REMOTE_LO;
   endsequence

   a_local_update: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      local_valid_i |=> st_reg.local_temp == $past(local_code_i))
      else $error("local reading not stored");

   a_pair_read: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_hi_read ##1 (!reg_wr_i)[*1] ##0 s_lo_read
      |=> reg_rdata_o[7:5] == $past(st_reg.remote[F-1:0], 2))
      else $error("low byte not from same conversion");

   a_low_zero: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_lo_read |=> reg_rdata_o[4:0] == 5'h00)
      else $error("low byte unused bits not zero");

   a_offset_add: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      filt_valid |=> st_reg.remote == $past(sum_sat))
      else $error("offset sum not stored");

   a_crit_hold: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      st_reg.crit_act && !crit_below |=> crit_o)
      else $error("critical released above hysteresis");

   a_crit_write: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == tsr_pkg::ADDR_CRIT
      |=> st_reg.crit == $past(reg_wdata_i))
      else $error("critical limit write lost");

   a_comp_mode: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      st_reg.mode[tsr_pkg::COMP_BIT] |-> alert_o == any_cond)
      else $error("comparator alert mismatch");

   a_int_latch: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !st_reg.mode[tsr_pkg::COMP_BIT] && any_cond
      && !reg_wr_i |=> alert_o)
      else $error("interrupt alert not latched");

   a_high_alarm: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $signed(st_reg.remote) > $signed(st_reg.rhigh) |-> alarm_o[2])
      else $error("remote high alarm missing");

   a_low_alarm: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $signed(st_reg.remote) < $signed(st_reg.rlow) |-> alarm_o[1])
      else $error("remote low alarm missing");

   a_mode_mask: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_rd_i && reg_addr_i == tsr_pkg::ADDR_FILT_MODE
      |=> reg_rdata_o[7:3] == 5'h00)
      else $error("mode unused bits not zero");

   a_pair_gap: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_hi_read ##1 !(reg_rd_i && reg_addr_i == tsr_pkg::ADDR_REMOTE_HI)
      ##1 s_lo_read
      |=> reg_rdata_o[7:5] == $past(st_reg.remote[F-1:0], 3))
      else $error("low byte not held across a gap");

   a_remote_read: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_hi_read |=> reg_rdata_o == $past(st_reg.remote[W-1:F]))
      else $error("remote high byte read wrong");

   a_local_read: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_rd_i && reg_addr_i == tsr_pkg::ADDR_LOCAL_TEMP
      |=> reg_rdata_o == $past(st_reg.local_temp))
      else $error("local reading read wrong");

   a_local_limit: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == tsr_pkg::ADDR_LOCAL_HIGH
      |=> st_reg.local_high == $past(reg_wdata_i))
      else $error("local high limit write lost");

   a_rhigh_int: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == tsr_pkg::ADDR_RHIGH_HI
      |=> st_reg.rhigh[W-1:F] == $past(reg_wdata_i))
      else $error("remote high limit write lost");

   a_rlow_frac: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == tsr_pkg::ADDR_RLOW_LO
      |=> st_reg.rlow[F-1:0] == $past(reg_wdata_i[7:5]))
      else $error("remote low limit fraction lost");

   a_offset_write: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == tsr_pkg::ADDR_ROFF_LO
      |=> st_reg.roff[F-1:0] == $past(reg_wdata_i[7:5]))
      else $error("offset fraction write lost");

   a_hyst_write: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == tsr_pkg::ADDR_CRIT_HYST
      |=> st_reg.hyst == $past(reg_wdata_i))
      else $error("hysteresis write lost");

   a_crit_set: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      crit_above |=> crit_o)
      else $error("critical not raised above limit");

   a_crit_clear: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !crit_above && crit_below |=> !crit_o)
      else $error("critical kept below hysteresis");

   a_mode_write: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == tsr_pkg::ADDR_FILT_MODE
      |=> st_reg.mode == $past(reg_wdata_i[2:0]))
      else $error("filter and mode write lost");

   a_query_clear: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !st_reg.mode[tsr_pkg::COMP_BIT] && alert_response_query_i
      && !any_cond && !reg_wr_i |=> !alert_o)
      else $error("query did not clear latched alert");
endmodule
`default_nettype wire

/* tsr_host_model.sv */
// Register host model for the temperature block's register port.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic query_o
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
      query_o = 1'b0;
   end
   // Released lines flip so stale values cannot pass as held
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
   // Unused mode bits always sent as zero
   task automatic wr_mode(input logic [2:0] m);
      wr(tsr_pkg::ADDR_FILT_MODE, {5'h00, m});
   endtask
   // High byte first so both bytes come from one conversion
   task automatic rd_remote(output logic [7:0] hi, output logic [7:0] lo);
      rd(tsr_pkg::ADDR_REMOTE_HI, hi);
      rd(tsr_pkg::ADDR_REMOTE_LO, lo);
   endtask
   task automatic query();
      @(posedge clk_i);
      query_o <= 1'b1;
      @(posedge clk_i);
      query_o <= 1'b0;
      #1;
   endtask
endmodule
`default_nettype wire

/* tsr_regs_tb_top.sv */
// Self-checking bench for the temperature result and limit registers.
// Assumes the host model drives the register port, filter off at start.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      samples_checked = samples_checked + 1; \
      if ((got) !== (exp)) begin \
         n_errors = n_errors + 1; \
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module tsr_regs_tb_top;
   logic clk_i;
   logic sys_rst_i;
   logic local_valid;
   logic [7:0] local_code;
   logic remote_valid;
   logic [10:0] remote_code;
   logic wr, rd, query, alert, crit;
   logic [7:0] addr, wdata, rdata;
   logic [3:0] alarm;
   int n_errors;
   int samples_checked;
   logic [7:0] ra [11] = '{8'h05, 8'h07, 8'h13, 8'h08, 8'h14, 8'h11,
      8'h12, 8'h19, 8'h21, 8'hbf, 8'h02};
   logic [7:0] rv [11] = '{8'h46, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h55, 8'h0a, 8'h00, 8'h00};
   tsr_host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr),
      .rd_o(rd), .addr_o(addr), .wdata_o(wdata), .query_o(query));
   tsr_regs u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .local_valid_i(local_valid), .local_code_i(local_code),
      .remote_valid_i(remote_valid), .remote_code_i(remote_code),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .alert_response_query_i(query),
      .reg_rdata_o(rdata), .alert_o(alert), .crit_o(crit),
      .alarm_o(alarm));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic give_verdict();
      $display("checked=%0d errors=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_host.rd(a, d);
      `CHK(d, e)
   endtask
   task automatic chk_remote(input logic [7:0] h, input logic [7:0] l);
      logic [7:0] dh, dl;
      u_host.rd_remote(dh, dl);
      `CHK({dh, dl}, {h, l})
   endtask
   // Stored two edges after the strobe; two spare edges for alarms
   task automatic samp(input logic [10:0] raw);
      @(posedge clk_i);
      remote_valid <= 1'b1;
      remote_code <= raw;
      @(posedge clk_i);
      remote_valid <= 1'b0;
      remote_code <= ~raw;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task automatic t_reset();
      for (int i = 0; i < 11; i++) begin
         chk_rd(ra[i], rv[i]);
      end
      u_host.wr(8'h19, 8'ha5);
      chk_rd(8'h19, 8'ha5);
      u_host.wr(8'h13, 8'hff);
      chk_rd(8'h13, 8'he0);
      u_host.wr(8'h13, 8'h00);
      u_host.wr(8'h19, 8'h55);
   endtask
   task automatic t_local();
      @(posedge clk_i);
      local_valid <= 1'b1;
      local_code <= 8'h5a;
      @(posedge clk_i);
      local_valid <= 1'b0;
      local_code <= 8'ha5;
      chk_rd(8'h00, 8'h5a);
      u_host.wr(8'h00, 8'hff);
      chk_rd(8'h00, 8'h5a);
      `CHK(alarm[3], 1'b1)
   endtask
   task automatic t_remote();
      // Offset of +1.5 degrees, then a negative raw code
      u_host.wr(8'h11, 8'h01);
      u_host.wr(8'h12, 8'h80);
      samp(11'h0c8);
      chk_remote(8'h1a, 8'h80);
      samp(11'h7f8);
      chk_remote(8'h00, 8'h80);
      u_host.wr(8'h11, 8'h00);
      u_host.wr(8'h12, 8'h00);
      // Fraction stays frozen while a new sample lands between the bytes
      chk_rd(8'h01, 8'h00);
      samp(11'h0c8);
      chk_rd(8'h10, 8'h80);
      samp(11'h0d4);
      chk_remote(8'h1a, 8'h80);
   endtask
   task automatic t_window();
      u_host.wr(8'h07, 8'h1a);
      u_host.wr(8'h13, 8'h60);
      #1;
      `CHK(alarm[2], 1'b1)
      u_host.wr(8'h13, 8'ha0);
      #1;
      `CHK(alarm[2], 1'b0)
      u_host.wr(8'h08, 8'h1a);
      u_host.wr(8'h14, 8'hc0);
      #1;
      `CHK(alarm[1], 1'b1)
      u_host.wr(8'h14, 8'h80);
      #1;
      `CHK(alarm[1], 1'b0)
   endtask
   task automatic t_alert();
      u_host.wr(8'h05, 8'h7f);
      u_host.query();
      `CHK(alert, 1'b0)
      u_host.wr(8'h13, 8'h60);
      @(posedge clk_i);
      #1;
      `CHK(alert, 1'b1)
      u_host.wr(8'h13, 8'ha0);
      #1;
      `CHK(alert, 1'b1)
      u_host.query();
      `CHK(alert, 1'b0)
      u_host.wr_mode(3'b001);
      u_host.wr(8'h13, 8'h60);
      #1;
      `CHK(alert, 1'b1)
      u_host.wr(8'h13, 8'ha0);
      #1;
      `CHK(alert, 1'b0)
   endtask
   task automatic t_crit();
      u_host.wr(8'h19, 8'h10);
      u_host.wr(8'h21, 8'h02);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK({crit, alarm[0]}, 2'b11)
      samp(11'h070);
      `CHK(crit, 1'b1)
      samp(11'h068);
      @(posedge clk_i);
      #1;
      `CHK(crit, 1'b0)
   endtask
   task automatic t_filter();
      u_host.wr_mode(3'b110);
      chk_rd(8'hbf, 8'h06);
      samp(11'h0a8);
      chk_remote(8'h0f, 8'h00);
      u_host.wr_mode(3'b010);
      samp(11'h0b8);
      chk_remote(8'h13, 8'h00);
      u_host.wr_mode(3'b100);
      samp(11'h0d8);
      chk_remote(8'h17, 8'h00);
      u_host.wr_mode(3'b000);
      samp(11'h0c8);
      chk_remote(8'h19, 8'h00);
   endtask
   initial begin
      #1ms;
      n_errors = n_errors + 1;
      give_verdict();
   end
   initial begin
      sys_rst_i = 1'b1;
      local_valid = 1'b0;
      local_code = 8'h00;
      remote_valid = 1'b0;
      remote_code = 11'h000;
      n_errors = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_local();
      t_remote();
      t_window();
      t_alert();
      t_crit();
      t_filter();
      give_verdict();
   end
endmodule
`default_nettype wire
